// ===== hrmd_top.sv
/*
 * register and memory access decoder for the host bus of the terminal core.
 * assumes host strobe, select, address and data come from an asynchronous bus;
 * all of them are synchronised here; engine status arrives on clk.
 */
`timescale 1ns/1ps
`include "hrmd_defs.svh"
module hrmd_top
    import hrmd_pkg::*;
#(
    parameter int           MEM_AW      = `HRMD_MEM_AW_DEF, // 11..16 gives 2K..64K
    parameter logic [15:0]  CORE_VER    = 16'h0A5C,         // arbitrary value
    parameter logic         BC_PRESENT  = 1'b1              // controller function fitted
)
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               host_strobe,                // access request, high
    input  wire logic               host_write,                 // 1 write, 0 read
    input  wire logic               memory_or_register_select,  // 0 reg, 1 mem
    input  wire logic [15:0]        host_addr,                  // shared address lines
    input  wire logic [15:0]        host_wdata,                 // shared data in
    input  wire logic               weapons_busy_startup_input, // strap
    input  wire logic [15:0]        stack_pointer_in,           // engine status words
    input  wire logic [15:0]        subaddr_ctrl_in,
    input  wire logic [15:0]        last_command_in,
    input  wire logic [15:0]        status_word_in,
    input  wire logic [15:0]        selftest_word_in,
    input  wire logic [15:0]        selftest_status_in,
    input  wire logic [15:0]        event1_in,                  // one-cycle event pulses
    input  wire logic [15:0]        event2_in,
    input  wire logic               tag_tick,                   // time tag increment
    input  wire logic               tag_latch,                  // latch time tag
    output logic [15:0]             host_rdata,                 // read data
    output logic                    host_ready,                 // access complete
    output logic                    start_cmd_pulse,            // offset 3 written
    output logic [15:0]             start_cmd_data,             // written command word
    output logic [15:0]             cfg1_out,
    output logic [15:0]             cfg7_out,
    output logic                    loopback_enable,            // test register usable
    output logic                    host_irq,                   // masked interrupt
    output logic                    mem_req,                    // memory access pulse
    output logic                    mem_we,
    output logic [MEM_AW-1:0]       mem_addr,
    output logic [15:0]             mem_wdata,
    output logic [15:0]             mem_rdata_q                 // last memory read
);
    //--------------------------------------------------------------------------
    // local storage
    //--------------------------------------------------------------------------
    logic [15:0]  mem_array [0:(1<<MEM_AW)-1];  // shared message memory [R02]
    logic [15:0]  mask1_r, mask2_r;             // interrupt masks
    logic [15:0]  cfg1_r, cfg2_r, cfg3_r, cfg4_r, cfg5_r, cfg6_r, cfg7_r;
    logic [15:0]  loop_r;                       // loopback test word
    logic [15:0]  stat1_r, stat2_r;             // sticky event status
    logic [15:0]  ttag_r, lttag_r;              // time tag and its latched copy
    logic [2:0]   stb_s;                        // strobe sync plus edge stage
    logic [1:0]   wr_s, sel_s, strap_s;
    logic [15:0]  addr_s1, addr_s2, wd_s1, wd_s2;
    hrmd_state_t  state_r;
    logic         strap_done_r;                 // strap captured once after release
    logic         acc;                          // one-cycle access strobe
    logic         reg_wr, reg_rd;
    logic [4:0]   off;                          // register offset
    logic [15:0]  rd_mux;

    //--------------------------------------------------------------------------
    // input synchronisers
    //--------------------------------------------------------------------------
    // two flops per pin, three on the strobe; logic uses the second stage, and the strobe edge detect also the third
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stb_s   <= 3'h0;
            wr_s    <= 2'h0;
            sel_s   <= 2'h0;
            addr_s1 <= `HRMD_ZERO16;
            addr_s2 <= `HRMD_ZERO16;
            wd_s1   <= `HRMD_ZERO16;
            wd_s2   <= `HRMD_ZERO16;
        end
        else
        begin
            stb_s   <= {stb_s[1:0], host_strobe};
            wr_s    <= {wr_s[0], host_write};
            sel_s   <= {sel_s[0], memory_or_register_select};
            addr_s1 <= host_addr;
            addr_s2 <= addr_s1;
            wd_s1   <= host_wdata;
            wd_s2   <= wd_s1;
        end
    end

    // strap flops keep running through reset, so the strap level is settled
    // by release; a reset value here would hide the busy start-up [R16]
    always_ff @(posedge clk)
    begin
        strap_s <= {strap_s[0], weapons_busy_startup_input};
    end

    //--------------------------------------------------------------------------
    // access sequencer
    //--------------------------------------------------------------------------
    // one access per strobe; host holds lines stable while strobe is high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_r <= HRMD_IDLE;
        else
        begin
            case (state_r)
                HRMD_IDLE: if (stb_s[1] && !stb_s[2]) state_r <= HRMD_BUSY;
                HRMD_BUSY: state_r <= HRMD_DONE;
                HRMD_DONE: if (!stb_s[1]) state_r <= HRMD_IDLE;
                default:   state_r <= HRMD_IDLE;
            endcase
        end
    end

    assign acc    = (state_r == HRMD_BUSY);
    assign off    = addr_s2[4:0];                     // [R19]
    assign reg_wr = acc && !sel_s[1] && wr_s[1];     // [R03]
    assign reg_rd = acc && !sel_s[1] && !wr_s[1];    // [R03]
    assign host_ready = (state_r == HRMD_DONE);       // combinational handshake

    //--------------------------------------------------------------------------
    // memory path
    //--------------------------------------------------------------------------
    // select high routes the access to the message memory [R03]
    always_ff @(posedge clk)
    begin
        if (acc && sel_s[1] && wr_s[1])
            mem_array[addr_s2[MEM_AW-1:0]] <= wd_s2;  // [R02]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_req     <= 1'b0;
            mem_we      <= 1'b0;
            mem_addr    <= '0;
            mem_wdata   <= `HRMD_ZERO16;
            mem_rdata_q <= `HRMD_ZERO16;
        end
        else
        begin
            mem_req <= acc && sel_s[1];
            if (acc && sel_s[1])
            begin
                mem_we    <= wr_s[1];
                mem_addr  <= addr_s2[MEM_AW-1:0];
                mem_wdata <= wd_s2;
                if (!wr_s[1])
                    mem_rdata_q <= mem_array[addr_s2[MEM_AW-1:0]];  // [R02]
            end
        end
    end

    //--------------------------------------------------------------------------
    // writable registers
    //--------------------------------------------------------------------------
    // defaults from reset, keep what host writes [R06] [R10]
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mask1_r <= `HRMD_ZERO16;
            mask2_r <= `HRMD_ZERO16;
            cfg2_r  <= `HRMD_ZERO16;
            cfg3_r  <= `HRMD_ZERO16;
            cfg4_r  <= `HRMD_ZERO16;
            cfg5_r  <= `HRMD_ZERO16;
            cfg6_r  <= `HRMD_ZERO16;
            cfg7_r  <= `HRMD_ZERO16;
            loop_r  <= `HRMD_ZERO16;
        end
        else if (reg_wr)
        begin
            case (off)
                `HRMD_OFF_MASK1: mask1_r <= wd_s2;   // [R06]
                `HRMD_OFF_MASK2: mask2_r <= wd_s2;   // [R10]
                `HRMD_OFF_CFG2:  cfg2_r  <= wd_s2;
                `HRMD_OFF_CFG3:  cfg3_r  <= wd_s2;
                `HRMD_OFF_CFG4:  cfg4_r  <= wd_s2;
                `HRMD_OFF_CFG5:  cfg5_r  <= wd_s2;
                `HRMD_OFF_CFG6:  cfg6_r  <= wd_s2;
                `HRMD_OFF_CFG7:  cfg7_r  <= wd_s2;
                `HRMD_OFF_LOOP:  loop_r  <= wd_s2;   // [R08]
                default:         ;                   // read-only, empty, or written in other blocks (0x01, 0x03, 0x05) [R05] [R17]
            endcase
        end
    end

    // config one: idle controller after reset, busy start-up if strap is high;
    // strap captured by a clocked step after release, never by the reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg1_r       <= `HRMD_CFG1_IDLE;          // [R16]
            strap_done_r <= 1'b0;
        end
        else if (!strap_done_r)
        begin
            strap_done_r <= 1'b1;
            cfg1_r       <= strap_s[1] ? `HRMD_CFG1_BUSY : `HRMD_CFG1_IDLE; // [R16]
        end
        else if (reg_wr && off == `HRMD_OFF_CFG1)
            cfg1_r <= wd_s2;                          // [R06]
    end

    //--------------------------------------------------------------------------
    // start/reset command
    //--------------------------------------------------------------------------
    // write to offset 3 fires a command; nothing is stored for reads [R07]
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            start_cmd_pulse <= 1'b0;
            start_cmd_data  <= `HRMD_ZERO16;
        end
        else
        begin
            start_cmd_pulse <= reg_wr && off == `HRMD_OFF_START;  // [R07]
            if (reg_wr && off == `HRMD_OFF_START)
                start_cmd_data <= wd_s2;
        end
    end

    //--------------------------------------------------------------------------
    // time tag
    //--------------------------------------------------------------------------
    // host write wins over the tick; latch copies the live count [R11]
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ttag_r  <= `HRMD_ZERO16;
            lttag_r <= `HRMD_ZERO16;
        end
        else
        begin
            if (reg_wr && off == `HRMD_OFF_TTAG)
                ttag_r <= wd_s2;                      // [R11]
            else if (tag_tick)
                ttag_r <= ttag_r + 16'h0001;
            if (tag_latch)
                lttag_r <= ttag_r;                    // [R11]
        end
    end

    //--------------------------------------------------------------------------
    // interrupt status
    //--------------------------------------------------------------------------
    // sticky, set whatever the mask; read clears, a new event wins the clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stat1_r <= `HRMD_ZERO16;
            stat2_r <= `HRMD_ZERO16;
        end
        else
        begin
            stat1_r <= ((reg_rd && off == `HRMD_OFF_STAT1) ? `HRMD_ZERO16 : stat1_r)
                       | event1_in;                   // [R15]
            stat2_r <= ((reg_rd && off == `HRMD_OFF_STAT2) ? `HRMD_ZERO16 : stat2_r)
                       | event2_in;                   // [R15]
        end
    end

    // mask only gates the interrupt line [R15]
    assign host_irq = |(stat1_r & mask1_r) || |(stat2_r & mask2_r);

    //--------------------------------------------------------------------------
    // read mux
    //--------------------------------------------------------------------------
    // twenty operational registers plus fixed slots [R04] [R01]
    always_comb
    begin
        rd_mux = `HRMD_ZERO16;                        // empty slots read zero [R17]
        case (off)
            `HRMD_OFF_MASK1:   rd_mux = mask1_r;
            `HRMD_OFF_CFG1:    rd_mux = cfg1_r;
            `HRMD_OFF_CFG2:    rd_mux = cfg2_r;
            `HRMD_OFF_START:   rd_mux = stack_pointer_in;    // [R07]
            `HRMD_OFF_SACW:    rd_mux = subaddr_ctrl_in;
            `HRMD_OFF_TTAG:    rd_mux = ttag_r;              // [R11]
            `HRMD_OFF_STAT1:   rd_mux = stat1_r;             // [R10]
            `HRMD_OFF_CFG3:    rd_mux = cfg3_r;
            `HRMD_OFF_CFG4:    rd_mux = cfg4_r;
            `HRMD_OFF_CFG5:    rd_mux = cfg5_r;
            `HRMD_OFF_LASTCMD: rd_mux = last_command_in;     // [R13]
            `HRMD_OFF_RTSTAT:  rd_mux = status_word_in;      // [R13]
            `HRMD_OFF_RTBIT:   rd_mux = selftest_word_in;    // [R13]
            `HRMD_OFF_LOOP:    rd_mux = loop_r;              // [R08]
            `HRMD_OFF_PATLO:   rd_mux = `HRMD_PAT_LO;        // [R18]
            `HRMD_OFF_PATHI:   rd_mux = `HRMD_PAT_HI;        // [R18]
            `HRMD_OFF_LTTAG:   rd_mux = lttag_r;             // [R11]
            `HRMD_OFF_CFG6:    rd_mux = cfg6_r;
            `HRMD_OFF_CFG7:    rd_mux = cfg7_out;            // [R09]
            `HRMD_OFF_VERSION: rd_mux = CORE_VER;            // [R12]
            `HRMD_OFF_BITSTAT: rd_mux = selftest_status_in;
            `HRMD_OFF_MASK2:   rd_mux = mask2_r;             // [R10]
            `HRMD_OFF_STAT2:   rd_mux = stat2_r;             // [R10]
            default:           rd_mux = `HRMD_ZERO16;        // [R17]
        endcase
    end

    // read data held from a flop until next read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            host_rdata <= `HRMD_ZERO16;
        else if (reg_rd)
            host_rdata <= rd_mux;
        else if (acc && sel_s[1] && !wr_s[1])
            host_rdata <= mem_array[addr_s2[MEM_AW-1:0]];
    end

    // bit 5 tracks bit 9, host cannot set it alone [R09]
    always_comb
    begin
        cfg7_out = cfg7_r;
        cfg7_out[`HRMD_CFG7_DST_BIT] = cfg7_r[`HRMD_CFG7_SRC_BIT];  // [R09]
    end

    assign cfg1_out        = cfg1_r;
    assign loopback_enable = BC_PRESENT && (loop_r != `HRMD_ZERO16);  // [R08]

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    sequence s_reg_write(logic [4:0] o);
        reg_wr && off == o;
    endsequence

    AST_START_PULSE: assert property (@(posedge clk) disable iff (rst)  // [R07]
        s_reg_write(`HRMD_OFF_START) |=> start_cmd_pulse)
        else $error("start command pulse missing");
    AST_PAT_LO: assert property (@(posedge clk) disable iff (rst)  // [R18]
        reg_rd && off == `HRMD_OFF_PATLO |=> host_rdata == `HRMD_PAT_LO)
        else $error("fixed low pattern wrong");
    AST_ZERO_SLOT: assert property (@(posedge clk) disable iff (rst)  // [R17]
        reg_rd && off == `HRMD_OFF_ZERO |=> host_rdata == `HRMD_ZERO16)
        else $error("empty slot not zero");
    AST_CFG7_TIE: assert property (@(posedge clk) disable iff (rst)  // [R09]
        reg_rd && off == `HRMD_OFF_CFG7
        |=> host_rdata[`HRMD_CFG7_DST_BIT] == host_rdata[`HRMD_CFG7_SRC_BIT])
        else $error("config seven bit tie broken");
    AST_STAT_STICKY: assert property (@(posedge clk) disable iff (rst)  // [R15]
        event1_in[0] |=> stat1_r[0])
        else $error("status bit not set by event");
    AST_MASK_KEEP: assert property (@(posedge clk) disable iff (rst)  // [R10]
        s_reg_write(`HRMD_OFF_MASK2) ##1 !reg_wr[*2] |-> mask2_r == $past(wd_s2, 2))
        else $error("mask two lost written value");
    AST_STAT_RO: assert property (@(posedge clk) disable iff (rst)  // [R05]
        s_reg_write(`HRMD_OFF_STAT1) ##0 event1_in == `HRMD_ZERO16
        |=> stat1_r == $past(stat1_r))
        else $error("status changed by write");
    AST_VERSION: assert property (@(posedge clk) disable iff (rst)  // [R12]
        reg_rd && off == `HRMD_OFF_VERSION |=> host_rdata == CORE_VER)
        else $error("version read wrong");
    AST_TTAG_WRITE: assert property (@(posedge clk) disable iff (rst)  // [R11]
        s_reg_write(`HRMD_OFF_TTAG) |=> ttag_r == $past(wd_s2))
        else $error("time tag lost host write");
    AST_READY: assert property (@(posedge clk) disable iff (rst)  // [R03]
        acc |=> host_ready)
        else $error("ready not raised after access");
endmodule // hrmd_top

// ===== hrmd_defs.svh
/*
 * constants for the host register map decoder: offsets, reset values, field positions.
 * assumes inclusion by bare name from the top module and the bench.
 */
`ifndef HRMD_DEFS_SVH
`define HRMD_DEFS_SVH
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// R01 - registers decoded in window 0x0 to 0x20
// R02 - message memory 2K to 64K sixteen-bit words
// R03 - select low registers, high memory, shared lines
// R04 - twenty operational registers: config, mode, interrupts
// R05 - read-only bits ignore writes, return fixed
// R06 - writable bits reset default, keep written value
// R07 - offset 3 write commands, read stack pointer
// R08 - offset 0x11 loopback test needs controller
// R09 - config seven bit5 follows bit9
// R10 - masks read/write, statuses read-only
// R11 - time tag read/write, latched copy readable
// R12 - offset 0x1A returns core version
// R13 - last command, status, selftest words readable
// R14 - host checks register and memory consistency
// R15 - status bits set regardless of mask
// R16 - config one resets idle, or busy start-up
// R17 - unimplemented offsets read zero, ignore writes
// R18 - offsets 0x12,0x13 return fixed patterns
// R19 - five low address lines select register
`define HRMD_OFF_MASK1    5'h00
`define HRMD_OFF_CFG1     5'h01
`define HRMD_OFF_CFG2     5'h02
`define HRMD_OFF_START    5'h03
`define HRMD_OFF_SACW     5'h04
`define HRMD_OFF_TTAG     5'h05
`define HRMD_OFF_STAT1    5'h06
`define HRMD_OFF_CFG3     5'h07
`define HRMD_OFF_CFG4     5'h08
`define HRMD_OFF_CFG5     5'h09
`define HRMD_OFF_ZERO     5'h0A
`define HRMD_OFF_LASTCMD  5'h0D
`define HRMD_OFF_RTSTAT   5'h0E
`define HRMD_OFF_RTBIT    5'h0F
`define HRMD_OFF_LOOP     5'h11
`define HRMD_OFF_PATLO    5'h12
`define HRMD_OFF_PATHI    5'h13
`define HRMD_OFF_LTTAG    5'h15
`define HRMD_OFF_CFG6     5'h18
`define HRMD_OFF_CFG7     5'h19
`define HRMD_OFF_VERSION  5'h1A
`define HRMD_OFF_BITSTAT  5'h1C
`define HRMD_OFF_MASK2    5'h1D
`define HRMD_OFF_STAT2    5'h1E
`define HRMD_PAT_LO       16'h3210
`define HRMD_PAT_HI       16'h7654
`define HRMD_ZERO16       16'h0000
`define HRMD_ONES16       16'hFFFF
`define HRMD_CFG1_IDLE    16'h0000
`define HRMD_CFG1_BUSY    16'h8000
`define HRMD_CFG7_SRC_BIT 9
`define HRMD_CFG7_DST_BIT 5
`define HRMD_MEM_AW_DEF   16
`endif

// ===== hrmd_pkg.sv
/*
 * types for the host register map decoder.
 * assumes hrmd_defs.svh sits in the same folder.
 */
package hrmd_pkg;
    //--------------------------------------------------------------------------
    // access phase of the host bus
    //--------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        HRMD_IDLE = 3'h1,  // waiting for a strobe
        HRMD_BUSY = 3'h2,  // strobe seen, access done
        HRMD_DONE = 3'h4   // wait for strobe release
    } hrmd_state_t;
endpackage

// ===== hrmd_host_model.sv
/*
 * host bus master model for the register map decoder.
 * assumes clk comes from the bench and host_ready is a level held until strobe drops.
 */
`timescale 1ns/1ps
module hrmd_host_model
(
    input  wire logic        clk,
    input  wire logic        host_ready,
    input  wire logic [15:0] host_rdata,
    input  wire logic        mem_req,
    output logic             host_strobe,
    output logic             host_write,
    output logic             memory_or_register_select,
    output logic [15:0]      host_addr,
    output logic [15:0]      host_wdata
);
    //--------------------------------------------------------------------------
    // idle bus at time zero
    //--------------------------------------------------------------------------
    initial
    begin
        host_strobe = 1'b0;
        host_write = 1'b0;
        memory_or_register_select = 1'b0;
        host_addr = 16'h0000;
        host_wdata = 16'h0000;
    end
    //--------------------------------------------------------------------------
    // one whole access; lines stay put until ready is sampled high
    //--------------------------------------------------------------------------
    task automatic access(input logic we, input logic sel, input logic [15:0] a,
                          input logic [15:0] wd, output logic [15:0] rd,
                          output logic mr, output bit ok);
        int n;
        ok = 1'b0;
        host_write = we;
        memory_or_register_select = sel; // low registers, high memory
        host_addr = a;
        host_wdata = wd;
        host_strobe = 1'b1;
        for (n = 0; n < 40 && !ok; n++)
        begin
            @(posedge clk);
            if (host_ready === 1'b1) ok = 1'b1;
        end
        rd = host_rdata;
        mr = mem_req;
        #1;
        host_strobe = 1'b0;
        // released address and data lines flip so stale values never look valid
        host_addr = ~a;
        host_wdata = ~wd;
        for (n = 0; n < 40 && host_ready !== 1'b0; n++) @(posedge clk);
        @(posedge clk);
        #1;
    endtask
endmodule // hrmd_host_model

// ===== host_register_map_decoder_tb_top.sv
/*
 * self-checking bench for hrmd_top with the host model as bus master.
 * assumes hrmd_defs.svh and hrmd_pkg are compiled first.
 */
`timescale 1ns/1ps
`include "hrmd_defs.svh"
module host_register_map_decoder_tb_top import hrmd_pkg::*;;
    localparam logic [15:0] VER = 16'h0B7E; // arbitrary value
    localparam logic [15:0] PAT = 16'h2AB5; // defined mask bits only
    logic clk = 1'b0, rst = 1'b1, weapons_busy_startup_input = 1'b0;
    logic tag_tick = 1'b0, tag_latch = 1'b0;
    logic [15:0] event1_in = 16'h0000, event2_in = 16'h0000;
    logic [15:0] stack_pointer_in = 16'h5A03, subaddr_ctrl_in = 16'h5A04;
    logic [15:0] last_command_in = 16'h5A0D, status_word_in = 16'h5A0E;
    logic [15:0] selftest_word_in = 16'h5A0F, selftest_status_in = 16'h5A1C;
    logic host_strobe, host_write, memory_or_register_select, host_ready;
    logic [15:0] host_addr, host_wdata, host_rdata, start_cmd_data, cfg1_out, cfg7_out;
    logic start_cmd_pulse, loopback_enable, host_irq, mem_req, mem_we, mr;
    logic [10:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata_q, r;
    bit ok;
    int mismatches = 0, checked = 0, cycles = 0, starts = 0;
    logic [4:0] rw[11] = '{5'h00, 5'h01, 5'h02, 5'h07, 5'h08, 5'h09, 5'h11, 5'h18,
                           5'h19, 5'h1D, 5'h05};
    logic [4:0] ro[6] = '{5'h03, 5'h04, 5'h0D, 5'h0E, 5'h0F, 5'h1C};
    logic [4:0] nz[5] = '{5'h0A, 5'h10, 5'h14, 5'h16, 5'h17};
    logic [4:0] st[2] = '{5'h06, 5'h1E};
    // small memory keeps address masking visible
    hrmd_top #(.MEM_AW(11), .CORE_VER(VER), .BC_PRESENT(1'b1)) DUT
    (
        .clk, .rst, .host_strobe, .host_write, .memory_or_register_select,
        .host_addr, .host_wdata, .weapons_busy_startup_input, .stack_pointer_in,
        .subaddr_ctrl_in, .last_command_in, .status_word_in, .selftest_word_in,
        .selftest_status_in, .event1_in, .event2_in, .tag_tick, .tag_latch,
        .host_rdata, .host_ready, .start_cmd_pulse, .start_cmd_data, .cfg1_out,
        .cfg7_out, .loopback_enable, .host_irq, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_rdata_q
    );
    hrmd_host_model acc
    (
        .clk, .host_ready, .host_rdata, .mem_req, .host_strobe, .host_write,
        .memory_or_register_select, .host_addr, .host_wdata
    );
    always #5 clk = ~clk;
    // hang guard well past the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (start_cmd_pulse === 1'b1) starts++;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out();
        end
    end
    task automatic close_out();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        acc.access(1'b1, 1'b0, a, d, r, mr, ok);
        chk({15'h0, ok}, 16'h0001);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        acc.access(1'b0, 1'b0, a, 16'h0000, r, mr, ok);
        chk(r, e);
    endtask
    task automatic pulse(input int k, input logic [15:0] v);
        if (k == 0) event1_in = v;
        else event2_in = v;
        @(posedge clk);
        #1;
        event1_in = 16'h0000;
        event2_in = 16'h0000;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic reset_dut(input logic s);
        weapons_busy_startup_input = s;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
    // registers programmed consistently before use
    initial
    begin
        reset_dut(1'b0);
        chk(cfg1_out, 16'h0000);
        chk({15'h0, loopback_enable}, 16'h0000);
        for (int k = 0; k < 2; k++)
        begin
            pulse(k, 16'h0001);
            chk({15'h0, host_irq}, 16'h0000);
            wr(st[k], 16'hFFFF);
            rd(st[k], 16'h0001);
            rd(st[k], 16'h0000);
        end
        foreach (rw[i])
        begin
            rd(rw[i], 16'h0000);
            wr(rw[i], PAT);
            rd(rw[i], PAT);
        end
        chk({15'h0, loopback_enable}, 16'h0001);
        for (int k = 0; k < 2; k++)
        begin
            pulse(k, 16'h0001);
            chk({15'h0, host_irq}, 16'h0001);
            rd(st[k], 16'h0001);
        end
        chk({15'h0, host_irq}, 16'h0000);
        wr(`HRMD_OFF_CFG7, 16'h0020);
        rd(`HRMD_OFF_CFG7, 16'h0000);
        wr(`HRMD_OFF_CFG7, 16'h0200);
        rd(`HRMD_OFF_CFG7, 16'h0220);
        chk(cfg7_out, 16'h0220);
        foreach (ro[i])
        begin
            wr(ro[i], 16'hFFFF);
            rd(ro[i], {8'h5A, 3'h0, ro[i]});
        end
        chk(start_cmd_data, 16'hFFFF);
        chk(starts[15:0], 16'h0001);
        foreach (nz[i])
        begin
            wr(nz[i], 16'hFFFF);
            rd(nz[i], 16'h0000);
        end
        wr(`HRMD_OFF_PATLO, 16'h0000);
        rd(16'hFFF2, 16'h3210);
        rd(16'hFFE0 | `HRMD_OFF_PATHI, 16'h7654);
        rd(`HRMD_OFF_VERSION, VER);
        wr(`HRMD_OFF_TTAG, 16'h0010);
        tag_tick = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        tag_tick = 1'b0;
        tag_latch = 1'b1;
        @(posedge clk);
        #1;
        tag_latch = 1'b0;
        rd(`HRMD_OFF_TTAG, 16'h0013);
        rd(`HRMD_OFF_LTTAG, 16'h0013);
        acc.access(1'b1, 1'b1, 16'h0923, 16'hBEEF, r, mr, ok);
        chk({15'h0, mr}, 16'h0001);
        chk({5'h0, mem_addr}, 16'h0123);
        chk(mem_wdata, 16'hBEEF);
        chk({15'h0, mem_we}, 16'h0001);
        // memory read through an aliased address must not reach offset 3
        acc.access(1'b0, 1'b1, 16'hF123, 16'h0000, r, mr, ok);
        chk(r, 16'hBEEF);
        chk(mem_rdata_q, 16'hBEEF);
        chk({15'h0, mem_we}, 16'h0000);
        reset_dut(1'b1);
        chk(cfg1_out, 16'h8000);
        rd(`HRMD_OFF_CFG1, 16'h8000);
        rd(`HRMD_OFF_MASK2, 16'h0000);
        close_out();
    end
endmodule // host_register_map_decoder_tb_top
